//--- rtl/ssl_pkg.sv
// Package for the serial switch latch control block
//
// Overview of operation
// - Each rising shift-clock edge shifts the data input into the 32-stage register and moves every bit one stage on.
// - A high-to-low edge of latch_load_n copies the whole shift register into the 32 latches.
// - With latch_load_n high the latches hold, and shifting never touches the switch states.
// - While latch_clear is high all 32 latches are forced to zero, opening every switch.
// - latch_clear never alters the shift register, which keeps shifting and keeps its data.
// - Each switch is driven only by its own latch bit.
// - Devices cascade by serial output to serial input, sharing clock, latch_load_n and latch_clear.
// - One falling latch_load_n edge updates every device in a chain at once.
// - The serial output follows stage 31 of the shift register.
// - While latch_load_n is low the latches are transparent to the shift register.
// - latch_clear has priority over every input except srst for the switch outputs.
package ssl_pkg;
	localparam int SSL_CHANNELS = 32;
	localparam int SSL_FIFO_DEPTH = 8;
	localparam int SSL_LAST_STAGE = 31;
	localparam logic [31:0] SSL_LATCH_RESET = 32'h00000000;
	localparam logic [31:0] SSL_SHIFT_RESET = 32'h00000000;
	localparam int SSL_CLK_MHZ = 100;
	localparam int SSL_SHIFT_MAX_MHZ = 20;
	localparam int SSL_SHIFT_MIN_CYCLES = (SSL_CLK_MHZ + SSL_SHIFT_MAX_MHZ - 1) / SSL_SHIFT_MAX_MHZ;

	typedef struct packed {
		logic dataIn;
		logic shiftEdge;
		logic latchLoadN;
		logic latchClear;
	} ssl_ctrl_type;
endpackage : ssl_pkg

//--- rtl/ssl_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module ssl_fifo #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output var  logic             inReady,
	output var  logic [WIDTH-1:0] outData,
	output var  logic             outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             doWr;
	logic             doRd;

	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	always_ff @(posedge ref_clk) begin
		if (doWr) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (doWr) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (doRd) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
		end
	end
endmodule : ssl_fifo
`default_nettype wire

//--- rtl/ssl_switch_latch.sv
// Serial shift register and switch latches, with input FIFO
`timescale 1ns/1ps
`default_nettype none
module ssl_switch_latch import ssl_pkg::*; #(
	parameter int CHANNELS = SSL_CHANNELS,
	parameter int DEPTH = SSL_FIFO_DEPTH
) (
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire logic                dataIn,
	input  wire logic                shiftClk,
	input  wire logic                latchLoadN,
	input  wire logic                latchClear,
	output var  logic                ctrlReady,
	output var  logic                dataOut,
	output var  logic [CHANNELS-1:0] switchCtrl
);
	// ----------------------------------------
	// Input sampling and event queue
	// ----------------------------------------
	logic         shiftClkQ;
	ssl_ctrl_type inEvent;
	ssl_ctrl_type headEvent;
	logic         inReady;
	logic         headValid;
	logic [CHANNELS-1:0] shiftReg;

	// One shift step, shared by the register and the transparent latch path
	function automatic logic [CHANNELS-1:0] shifted(input logic [CHANNELS-1:0] cur, input logic bitIn);
		return {cur[CHANNELS-2:0], bitIn};
	endfunction : shifted

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shiftClkQ <= 1'b0;
		end else begin
			shiftClkQ <= shiftClk;
		end
	end

	always_comb begin
		inEvent.dataIn = dataIn;
		inEvent.shiftEdge = shiftClk && !shiftClkQ;
		inEvent.latchLoadN = latchLoadN;
		inEvent.latchClear = latchClear;
	end

	// Queue delays the pin events by one cycle; its drain is always ready, so it never fills
	ssl_fifo #(
		.WIDTH($bits(ssl_ctrl_type)),
		.DEPTH(DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.srst    (srst),
		.inData  (inEvent),
		.inValid (1'b1),
		.inReady (inReady),
		.outData (headEvent),
		.outValid(headValid),
		.outReady(1'b1)
	);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrlReady <= 1'b0;
		end else begin
			ctrlReady <= inReady;
		end
	end

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	// Clear is deliberately absent here so data survives a clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shiftReg <= CHANNELS'(SSL_SHIFT_RESET);
		end else if (headValid && headEvent.shiftEdge) begin
			shiftReg <= shifted(shiftReg, headEvent.dataIn);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dataOut <= 1'b0;
		end else if (headValid && headEvent.shiftEdge) begin
			dataOut <= shiftReg[CHANNELS-2];
		end
	end

	// ----------------------------------------
	// Latches
	// ----------------------------------------
	// Bit i drives switch i alone; one means closed
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			switchCtrl <= CHANNELS'(SSL_LATCH_RESET);
		end else if (headValid) begin
			if (headEvent.latchClear) begin
				switchCtrl <= CHANNELS'(SSL_LATCH_RESET);
			end else if (!headEvent.latchLoadN) begin
				// Falling edge and low level both pass the register through
				switchCtrl <= headEvent.shiftEdge
					? shifted(shiftReg, headEvent.dataIn)
					: shiftReg;
			end else begin
				switchCtrl <= switchCtrl;
			end
		end
	end
endmodule : ssl_switch_latch
`default_nettype wire

//--- verification/ssl_switch_latch_properties.sv
// Port checker of the switch latch block
`timescale 1ns/1ps
`default_nettype none
module ssl_switch_latch_properties #(parameter int CHANNELS = 32) (
	input wire logic	ref_clk,
	input wire logic	srst,
	input wire logic	dataIn,
	input wire logic	shiftClk,
	input wire logic	latchLoadN,
	input wire logic	latchClear,
	input wire logic	dataOut,
	input wire logic [CHANNELS-1:0]	switchCtrl
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_clr; latchClear[*3] |-> switchCtrl == '0; endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_clrz; $rose(latchClear) |-> ##[1:2] switchCtrl == '0; endproperty
	a_clrz: assert property (p_clrz) else $error("clear late");
	property p_keep; latchClear ##1 (latchLoadN && !latchClear)[*3] |-> switchCtrl == '0; endproperty
	a_keep: assert property (p_keep) else $error("keep");
	property p_hold; (latchLoadN && !latchClear)[*3] |-> $stable(switchCtrl); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_dout; $changed(dataOut) |-> $past(shiftClk, 2) && !$past(shiftClk, 3); endproperty
	a_dout: assert property (p_dout) else $error("dout");
	property p_thru; (!latchLoadN && !latchClear)[*4] |-> switchCtrl[CHANNELS-1] == dataOut; endproperty
	a_thru: assert property (p_thru) else $error("thru");
	property p_move; (!latchLoadN && !latchClear)[*5] ##0 $changed(switchCtrl) |->
		switchCtrl[CHANNELS-1:1] == $past(switchCtrl[CHANNELS-2:0]); endproperty
	a_move: assert property (p_move) else $error("move");
	property p_din; (!latchLoadN && !latchClear)[*5] ##0 $changed(switchCtrl) |-> switchCtrl[0] == $past(dataIn, 2); endproperty
	a_din: assert property (p_din) else $error("din");
endmodule : ssl_switch_latch_properties
bind ssl_switch_latch ssl_switch_latch_properties #(.CHANNELS(CHANNELS)) u_chk (
	.ref_clk   (ref_clk),
	.srst      (srst),
	.dataIn    (dataIn),
	.shiftClk  (shiftClk),
	.latchLoadN(latchLoadN),
	.latchClear(latchClear),
	.dataOut   (dataOut),
	.switchCtrl(switchCtrl)
);
`default_nettype wire

//--- verification/ssl_host_model.sv
// Host controller model driving the serial control pins
`timescale 1ns/1ps
`default_nettype none
module ssl_host_model (
	input wire logic	ref_clk,
	input wire logic	dataOut,
	output var logic	dataIn,
	output var logic	shiftClk,
	output var logic	latchLoadN,
	output var logic	latchClear
);
	initial {dataIn, shiftClk, latchLoadN, latchClear} = 4'h2;
	// A half period of 3 cycles or more keeps the shift clock below its ceiling
	task send(input logic [31:0] w, input int half, input logic le, output logic [31:0] rb);
		latchLoadN <= le;
		for (int i = 31; i >= 0; i--) begin
			dataIn <= w[i];
			repeat (half) @(negedge ref_clk);
			rb[i] = dataOut;
			shiftClk <= 1'h1;
			repeat (half) @(negedge ref_clk);
			shiftClk <= 1'h0;
		end
		dataIn <= ~dataIn;
		repeat (4) @(negedge ref_clk);
	endtask : send
	task set_clear(input logic c);
		latchClear <= c;
	endtask : set_clear
	task load();
		repeat (4) @(negedge ref_clk);
		latchLoadN <= 1'h0;
		repeat (4) @(negedge ref_clk);
		latchLoadN <= 1'h1;
		repeat (3) @(negedge ref_clk);
	endtask : load
endmodule : ssl_host_model
`default_nettype wire

//--- verification/ssl_switch_latch_tb.sv
// Self-checking bench of the switch latch block
`timescale 1ns/1ps
`default_nettype none
module ssl_switch_latch_tb;
	logic	ref_clk = 1'h0;
	logic	srst = 1'h1;
	logic	ctrlReady, dataOut;
	wire logic	dataIn, shiftClk, latchLoadN, latchClear;
	logic [31:0]	switchCtrl, w, rb, lat = 32'h0, prev = 32'h0, seed = 32'h5D1A;
	int	miscompares = 0, tests_run = 0, cyc = 0;
	ssl_switch_latch ssl_switch_latch_inst (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.dataIn    (dataIn),
		.shiftClk  (shiftClk),
		.latchLoadN(latchLoadN),
		.latchClear(latchClear),
		.ctrlReady (ctrlReady),
		.dataOut   (dataOut),
		.switchCtrl(switchCtrl)
	);
	ssl_host_model host (
		.ref_clk   (ref_clk),
		.dataOut   (dataOut),
		.dataIn    (dataIn),
		.shiftClk  (shiftClk),
		.latchLoadN(latchLoadN),
		.latchClear(latchClear)
	);
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic [31:0] held(input logic [31:0] v, input logic clr);
		return clr ? 32'h0 : v;
	endfunction : held
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) miscompares++;
		if (g !== e) $display("[FAIL] %s expected %h seen %h", n, e, g);
	endtask : chk
	task results();
		$display("checks %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	initial forever #5 ref_clk = ~ref_clk;
	// Six loads need about 2200 cycles
	always @(posedge ref_clk) if (++cyc == 20000) begin
		miscompares++;
		results();
	end
	initial begin
		repeat (20) @(negedge ref_clk);
		srst = 1'h0;
		repeat (3) @(negedge ref_clk);
		chk("ready", 32'h1, {31'h0, ctrlReady});
		for (int t = 0; t < 6; t++) begin
			w = t == 0 ? 32'hFFFFFFFF : t == 1 ? 32'h0 : xs();
			host.set_clear(t == 3);
			host.send(w, t[0] ? 8 : 3, t != 5, rb);
			chk("readback", prev, rb);
			chk("hold", t == 5 ? w : held(lat, t == 3), switchCtrl);
			host.set_clear(1'h0);
			host.load();
			chk("load", w, switchCtrl);
			lat = w;
			prev = w;
			$display("test %0d done", t);
		end
		results();
	end
endmodule : ssl_switch_latch_tb
`default_nettype wire
